// ===== logic/cpudbg_map.svh
/*
  Constants for the opcode subset and debug step block: command bytes,
  opcodes, flag positions, cycle counts.
  Assumes inclusion by bare name from the package and the design files.
*/
`ifndef CPUDBG_MAP_SVH
`define CPUDBG_MAP_SVH

// ==============================
// debug command bytes
`define CMD_STEP      8'h10
`define CMD_STUFF     8'h11
`define CMD_EXEC      8'h12

// ==============================
// opcodes
`define OP_ATOMIC     8'h2F
`define OP_REVERSE    8'hD5
`define OP_BTJ_R      8'hF6
`define OP_BTJ_IR     8'hF7
`define OP_TRAP       8'hF2
`define OP_AND_EXTENDED_OP_ER    8'h58
`define OP_AND_EXTENDED_OP_IM    8'h59
`define OP_XOR_EXTENDED_OP_ER    8'hB8
`define OP_XOR_EXTENDED_OP_IM    8'hB9

// ==============================
// flag bit positions in the flags byte
`define FL_C          7
`define FL_Z          6
`define FL_S          5
`define FL_V          4

// ==============================
// lengths, cycle counts, atomic span and stack decrements
`define LEN_ATOMIC    3'h1
`define LEN_TWO       3'h2
`define LEN_THREE     3'h3
`define LEN_FOUR      3'h4
`define CYC_ATOMIC    3'h2
`define CYC_TWO       3'h2
`define CYC_THREE     3'h3
`define CYC_FOUR      3'h4
`define CYC_TRAP      3'h6
`define ATOMIC_SPAN   2'h3
`define SP_PC_DEC     8'h02
`define SP_FL_DEC     8'h01

`endif

// ===== logic/cpudbg_pkg.sv
/*
  Types shared by the opcode decoder and the debug front end.
  Assumes the map header is on the include path.
*/
`include "cpudbg_map.svh"
package cpudbg_pkg;
  // gray coded along idle -> load -> exec -> done
  typedef enum logic [2:0] {
    CD_IDLE = 3'b000,
    CD_OPND = 3'b001,
    CD_EXEC = 3'b011,
    CD_DONE = 3'b010,
    CD_CMD  = 3'b110
  } cpudbg_state_t;

  typedef struct packed {
    logic [2:0] len;
    logic [2:0] cyc;
  } cpudbg_shape_t;
endpackage

// ===== logic/cpudbg_alu.sv
/*
  Combinational result and flag logic for the supported opcodes.
  Assumes operands already fetched; flags byte with C,Z,S,V at the map positions.
*/
`timescale 1ns/10ps
`default_nettype none
`include "cpudbg_map.svh"
module cpudbg_alu
  import cpudbg_pkg::*;
(
  input  wire logic [7:0] op,       // opcode
  input  wire logic [7:0] a,        // destination operand
  input  wire logic [7:0] b,        // source operand
  input  wire logic [7:0] flags_in, // current flags
  output logic      [7:0] result,   // value to write back
  output logic      [7:0] flags_out,// updated flags
  output logic            wr_en     // result must be stored
);
  // ==============================
  // result and flags
  always_comb begin
    result    = a;
    flags_out = flags_in;
    wr_en     = 1'b0;
    case (op)
      `OP_AND_EXTENDED_OP_ER, `OP_AND_EXTENDED_OP_IM: begin
        result = a & b; // RULE_12
        wr_en  = 1'b1;
      end
      `OP_XOR_EXTENDED_OP_ER, `OP_XOR_EXTENDED_OP_IM: begin
        result = a ^ b; // RULE_13
        wr_en  = 1'b1;
      end
      `OP_REVERSE: begin
        for (int i = 0; i < 8; i++) begin
          result[i] = a[7-i]; // RULE_10
        end
        wr_en = 1'b1;
      end
      default: begin
        result = a;
      end
    endcase
    if (wr_en) begin
      // z and s follow the result, v forced clear, the rest untouched; RULE_08
      flags_out[`FL_Z] = (result == 8'h00);
      flags_out[`FL_S] = result[7];
      flags_out[`FL_V] = 1'b0;
      // carry is undefined for reverse: kept as is
    end
  end
endmodule
`default_nettype wire

// ===== logic/cpudbg_core.sv
/*
  Debug command front end plus decode/execute of a small opcode subset:
  atomic prefix, bit reverse, bit test and jump, trap, extended AND/XOR.
  Assumes command bytes arrive as a strobed byte from the debug pin receiver,
  a program memory and register file that answer in the same cycle.
*/
// What this block does
// RULE_01 - step command runs one instruction at PC
// RULE_02 - stuff: given first byte, then execute it
// RULE_03 - stuffed remaining bytes come from program memory
// RULE_04 - execute command takes whole instruction from host
// RULE_05 - indexed address adds signed 8-bit index
// RULE_06 - trap vector spans whole byte, selects PC source
// RULE_07 - atomic prefix masks interrupts for three instructions
// RULE_08 - flags follow result, unchanged, undefined or forced
// RULE_09 - trap pushes PC, then flags, loads vector
// RULE_10 - bit reverse mirrors byte, clears overflow
// RULE_11 - bit test jump branches on polarity match
// RULE_12 - extended AND writes result, sets Z S
// RULE_13 - extended XOR writes result, sets Z S
`timescale 1ns/10ps
`default_nettype none
`include "cpudbg_map.svh"
module cpudbg_core
  import cpudbg_pkg::*;
#(
  parameter int AW = 16                   // program address width
) (
  input  wire logic          CLK,         // system clock
  input  wire logic          RST,         // sync reset, active high
  input  wire logic          DBG_VALID,   // byte from debug_serial_pin receiver
  input  wire logic [7:0]    DBG_BYTE,    // received byte
  input  wire logic          DEBUG_MODE,  // debug_unit in debug state
  input  wire logic          READ_PROT,   // flash read protection on
  input  wire logic [7:0]    PM_RDATA,    // program memory data
  input  wire logic [7:0]    RF_RDATA,    // register file data at RF_ADDR
  input  wire logic [7:0]    INDEX,       // signed index for indexed mode
  input  wire logic [11:0]   BASE_ADDR,   // base register address
  output logic [AW-1:0]      PM_ADDR,     // program memory address
  output logic [11:0]        RF_ADDR,     // register/data address
  output logic [7:0]         RF_WDATA,    // register write data
  output logic               RF_WE,       // register write strobe
  output logic [11:0]        EA,          // indexed effective address
  output logic [AW-1:0]      PC,          // program counter
  output logic [11:0]        SP,          // stack pointer
  output logic [7:0]         FLAGS,       // flags register
  output logic               IRQ_BLOCK,   // interrupts and DMA blocked
  output logic               BUSY         // instruction in progress
);
  // ==============================
  // helpers
  function automatic cpudbg_shape_t shape(input logic [7:0] op);
    cpudbg_shape_t s;
    s.len = `LEN_TWO;
    s.cyc = `CYC_TWO;
    case (op)
      `OP_ATOMIC: begin
        s.len = `LEN_ATOMIC;
        s.cyc = `CYC_ATOMIC;
      end
      `OP_TRAP: begin
        s.len = `LEN_TWO;
        s.cyc = `CYC_TRAP;
      end
      `OP_BTJ_R: begin
        s.len = `LEN_THREE;
        s.cyc = `CYC_THREE;
      end
      `OP_BTJ_IR: begin
        s.len = `LEN_THREE;
        s.cyc = `CYC_FOUR;
      end
      `OP_AND_EXTENDED_OP_ER, `OP_AND_EXTENDED_OP_IM, `OP_XOR_EXTENDED_OP_ER, `OP_XOR_EXTENDED_OP_IM: begin
        s.len = `LEN_FOUR;
        s.cyc = `CYC_THREE;
      end
      default: begin
        s.len = `LEN_TWO;
        s.cyc = `CYC_TWO;
      end
    endcase
    return s;
  endfunction

  function automatic logic [11:0] idx_addr(input logic [11:0] base, input logic [7:0] ix);
    return base + {{4{ix[7]}}, ix}; // RULE_05
  endfunction

  // operand register address that the result goes back to
  function automatic logic [11:0] dst_addr(input logic [7:0] opc, input logic [7:0] b1,
                                           input logic [7:0] b2);
    case (opc)
      `OP_AND_EXTENDED_OP_ER, `OP_AND_EXTENDED_OP_IM, `OP_XOR_EXTENDED_OP_ER, `OP_XOR_EXTENDED_OP_IM: return {b1[3:0], b2};
      `OP_BTJ_R, `OP_BTJ_IR: return {8'h00, b1[3:0]};
      default: return {4'h0, b1};
    endcase
  endfunction

  // ==============================
  // state
  cpudbg_state_t     st_q, st_d;
  logic [7:0]        cmd_q, cmd_d;
  logic [7:0]        ib_q [0:3];
  logic [7:0]        ib_d [0:3];
  logic [2:0]        cnt_q, cnt_d;
  logic [2:0]        len_q, len_d;
  logic [2:0]        cyc_q, cyc_d;
  logic              host_q, host_d;
  logic [AW-1:0]     pc_q, pc_d, pm_q, pm_d;
  logic [11:0]       sp_q, sp_d, ra_q, ra_d;
  logic [7:0]        fl_q, fl_d, wd_q, wd_d;
  logic              we_q, we_d, busy_q, busy_d;
  logic [1:0]        atm_q, atm_d;
  logic              irq_q, irq_d;
  logic [7:0]        opb_q, opb_d;
  cpudbg_shape_t     shp_byte, shp_pm;
  logic [11:0]       ea_q, ea_d;
  logic [7:0]        alu_res, alu_fl;
  logic              alu_we;
  logic              allowed;
  logic [7:0]        op;
  logic [7:0]        src_bit;
  logic              hit;

  assign allowed = DEBUG_MODE && !READ_PROT; // RULE_01
  assign op      = ib_q[0];
  assign shp_byte = shape(DBG_BYTE);
  assign shp_pm   = shape(PM_RDATA);

  cpudbg_alu cpudbg_alu_inst (
    .op        (op),
    .a         (RF_RDATA),
    .b         ((op == `OP_AND_EXTENDED_OP_ER || op == `OP_XOR_EXTENDED_OP_ER) ? opb_q : ib_q[3]),
    .flags_in  (fl_q),
    .result    (alu_res),
    .flags_out (alu_fl),
    .wr_en     (alu_we)
  );

  // ==============================
  // next state
  always_comb begin
    st_d   = st_q;
    cmd_d  = cmd_q;
    for (int i = 0; i < 4; i++) ib_d[i] = ib_q[i];
    cnt_d  = cnt_q;
    len_d  = len_q;
    cyc_d  = cyc_q;
    host_d = host_q;
    pc_d   = pc_q;
    pm_d   = pm_q;
    sp_d   = sp_q;
    ra_d   = ra_q;
    fl_d   = fl_q;
    wd_d   = wd_q;
    we_d   = 1'b0;
    busy_d = busy_q;
    atm_d  = atm_q;
    opb_d  = opb_q;
    ea_d   = idx_addr(BASE_ADDR, INDEX);
    src_bit = RF_RDATA;
    hit    = 1'b0;
    case (st_q)
      CD_IDLE: begin
        busy_d = 1'b0;
        if (DBG_VALID && allowed) begin
          case (DBG_BYTE)
            `CMD_STEP: begin
              host_d = 1'b0; // RULE_01
              pm_d   = pc_q;
              cnt_d  = 3'h0;
              len_d  = `LEN_ATOMIC;
              busy_d = 1'b1;
              st_d   = CD_OPND;
            end
            `CMD_STUFF, `CMD_EXEC: begin
              cmd_d  = DBG_BYTE;
              busy_d = 1'b1;
              st_d   = CD_CMD;
            end
            default: st_d = CD_IDLE;
          endcase
        end
      end
      CD_CMD: begin
        if (DBG_VALID) begin
          ib_d[0] = DBG_BYTE; // RULE_02
          len_d   = shp_byte.len;
          cnt_d   = 3'h1;
          host_d  = (cmd_q == `CMD_EXEC); // RULE_04
          pm_d    = pc_q + AW'(1); // RULE_03
          st_d    = (shp_byte.len == `LEN_ATOMIC) ? CD_EXEC : CD_OPND;
          cyc_d   = shp_byte.cyc;
        end
      end
      CD_OPND: begin
        // bytes come from the host only for execute; step and stuff read memory
        if (host_q ? DBG_VALID : 1'b1) begin
          ib_d[cnt_q[1:0]] = host_q ? DBG_BYTE : PM_RDATA; // RULE_03 RULE_04
          if (cnt_q == 3'h0) begin
            len_d = shp_pm.len;
            cyc_d = shp_pm.cyc;
          end
          if (!host_q) pm_d = pm_q + AW'(1);
          if ((cnt_q + 3'h1) >= ((cnt_q == 3'h0) ? shp_pm.len : len_q)) begin
            st_d = CD_EXEC;
          end
          cnt_d = cnt_q + 3'h1;
        end
        // built from the bytes seen so far, so it is right once the last lands
        ra_d = dst_addr(ib_d[0], ib_d[1], ib_d[2]);
      end
      CD_EXEC: begin
        // execution cycles counted so timing matches the instruction
        cyc_d = cyc_q - 3'h1;
        // register source: read it first, then point back at the destination
        if (op == `OP_AND_EXTENDED_OP_ER || op == `OP_XOR_EXTENDED_OP_ER) begin
          if (cyc_q == `CYC_THREE) begin
            ra_d = {ib_q[1][7:4], ib_q[3]}; // RULE_12 RULE_13
          end
          if (cyc_q == `CYC_TWO) begin
            opb_d = RF_RDATA;
            ra_d  = dst_addr(op, ib_q[1], ib_q[2]);
          end
        end
        if (cyc_q <= 3'h1) begin
          st_d = CD_DONE;
          if (!host_q || cmd_q == `CMD_STUFF) pc_d = pc_q + AW'(len_q);
          if (atm_q != 2'h0) atm_d = atm_q - 2'h1; // RULE_07
          case (op)
            `OP_ATOMIC: atm_d = `ATOMIC_SPAN; // RULE_07
            `OP_TRAP: begin
              sp_d = sp_q - 12'(`SP_PC_DEC) - 12'(`SP_FL_DEC); // RULE_09
              pc_d = AW'({RF_RDATA, PM_RDATA}); // RULE_06
            end
            `OP_BTJ_R, `OP_BTJ_IR: begin
              src_bit = RF_RDATA >> ib_q[1][6:4];
              hit = (src_bit[0] == ib_q[1][7]); // RULE_11
              if (hit) pc_d = pc_q + AW'(len_q) + AW'({{(AW-8){ib_q[2][7]}}, ib_q[2]});
            end
            default: begin
              if (alu_we) begin
                wd_d = alu_res; // RULE_10 RULE_12 RULE_13
                we_d = 1'b1;
                fl_d = alu_fl; // RULE_08
              end
            end
          endcase
        end else if (op == `OP_TRAP) begin
          // stack writes: PC pair first, flags last
          we_d = 1'b1;
          case (cyc_q)
            3'h6: begin
              ra_d = sp_q - 12'h001;
              wd_d = pc_q[7:0];
            end
            3'h5: begin
              ra_d = sp_q - 12'h002;
              wd_d = 8'(pc_q >> 8);
            end
            3'h4: begin
              ra_d = sp_q - 12'h003;
              wd_d = fl_q;
            end
            default: begin
              // both memories point at the vector before the last cycle reads them
              ra_d = {4'h0, ib_q[1]}; // RULE_06
              pm_d = AW'(ib_q[1]); // RULE_06
              we_d = 1'b0;
            end
          endcase
        end
      end
      CD_DONE: begin
        busy_d = 1'b0;
        st_d   = CD_IDLE;
      end
      default: st_d = CD_IDLE;
    endcase
    irq_d = (atm_d != 2'h0); // RULE_07
  end

  // ==============================
  // registers
  always_ff @(posedge CLK) begin
    if (RST) begin
      st_q   <= CD_IDLE;
      cmd_q  <= 8'h00;
      for (int i = 0; i < 4; i++) ib_q[i] <= 8'h00;
      cnt_q  <= 3'h0;
      len_q  <= 3'h0;
      cyc_q  <= 3'h0;
      host_q <= 1'b0;
      pc_q   <= '0;
      pm_q   <= '0;
      sp_q   <= 12'h000;
      ra_q   <= 12'h000;
      fl_q   <= 8'h00;
      wd_q   <= 8'h00;
      we_q   <= 1'b0;
      busy_q <= 1'b0;
      atm_q  <= 2'h0;
      irq_q  <= 1'b0;
      opb_q  <= 8'h00;
      ea_q   <= 12'h000;
    end else begin
      st_q   <= st_d;
      cmd_q  <= cmd_d;
      for (int i = 0; i < 4; i++) ib_q[i] <= ib_d[i];
      cnt_q  <= cnt_d;
      len_q  <= len_d;
      cyc_q  <= cyc_d;
      host_q <= host_d;
      pc_q   <= pc_d;
      pm_q   <= pm_d;
      sp_q   <= sp_d;
      ra_q   <= ra_d;
      fl_q   <= fl_d;
      wd_q   <= wd_d;
      we_q   <= we_d;
      busy_q <= busy_d;
      atm_q  <= atm_d;
      irq_q  <= irq_d;
      opb_q  <= opb_d;
      ea_q   <= ea_d;
    end
  end

  assign PM_ADDR   = pm_q;
  assign RF_ADDR   = ra_q;
  assign RF_WDATA  = wd_q;
  assign RF_WE     = we_q;
  assign EA        = ea_q;
  assign PC        = pc_q;
  assign SP        = sp_q;
  assign FLAGS     = fl_q;
  assign IRQ_BLOCK = irq_q; // RULE_07
  assign BUSY      = busy_q;

  // ==============================
  // checks
  chk_cmd_ignored: assert property (@(posedge CLK) disable iff (RST)
    (st_q == CD_IDLE && DBG_VALID && !allowed) |=> st_q == CD_IDLE) // RULE_01
    else $error("command accepted while locked");
  chk_stuff_opcode: assert property (@(posedge CLK) disable iff (RST)
    (st_q == CD_CMD && DBG_VALID) |=> ib_q[0] == $past(DBG_BYTE)) // RULE_02
    else $error("stuffed opcode not captured");
  chk_exec_src: assert property (@(posedge CLK) disable iff (RST)
    (st_q == CD_CMD && DBG_VALID) |=> host_q == ($past(cmd_q) == `CMD_EXEC)) // RULE_03
    else $error("operand source wrong");
  chk_atomic_blk: assert property (@(posedge CLK) disable iff (RST)
    (st_q == CD_EXEC && cyc_q <= 3'h1 && op == `OP_ATOMIC) |=> IRQ_BLOCK && atm_q == 2'h3) // RULE_07
    else $error("atomic span not loaded");
  chk_trap_sp: assert property (@(posedge CLK) disable iff (RST)
    (st_q == CD_EXEC && cyc_q <= 3'h1 && op == `OP_TRAP) |=> SP == $past(SP) - 12'h003) // RULE_09
    else $error("trap stack adjust wrong");
  chk_flag_v: assert property (@(posedge CLK) disable iff (RST)
    (st_q == CD_EXEC && cyc_q <= 3'h1 && alu_we && op != `OP_TRAP && op != `OP_ATOMIC)
    |=> !FLAGS[`FL_V] && RF_WE) // RULE_08
    else $error("overflow not cleared");
  chk_idx_ea: assert property (@(posedge CLK) disable iff (RST)
    1'b1 |=> EA == $past(BASE_ADDR) + {{4{$past(INDEX[7])}}, $past(INDEX)}) // RULE_05
    else $error("indexed address wrong");
  chk_done_idle: assert property (@(posedge CLK) disable iff (RST)
    st_q == CD_DONE |=> st_q == CD_IDLE ##0 !BUSY) // RULE_04
    else $error("done not followed by idle");
  cov_step: cover property (@(posedge CLK) st_q == CD_IDLE && DBG_VALID && allowed && DBG_BYTE == `CMD_STEP);
  cov_stuff: cover property (@(posedge CLK) st_q == CD_CMD && cmd_q == `CMD_STUFF && DBG_VALID);
  cov_trap: cover property (@(posedge CLK) st_q == CD_EXEC && op == `OP_TRAP);
endmodule
`default_nettype wire

// ===== dv/cpudbg_host.sv
/*
  Behavioural debug host: hands command and instruction bytes to the core,
  one strobe per byte.
  Assumes the core samples DBG_VALID on the rising edge of CLK.
*/
`timescale 1ns/10ps
`default_nettype none
module cpudbg_host (
  input  wire logic       CLK,       // system clock
  output logic            DBG_VALID, // byte strobe
  output logic      [7:0] DBG_BYTE   // byte to the core
);
  initial begin
    DBG_VALID = 1'b0;
    DBG_BYTE  = 8'h00;
  end

  // ==============================
  // byte transfer
  task automatic send(input logic [7:0] b);
    @(posedge CLK);
    #1;
    DBG_VALID = 1'b1;
    DBG_BYTE  = b;
    @(posedge CLK);
    #1;
    DBG_VALID = 1'b0;
    // scrambled so a stale byte never passes for fresh data
    DBG_BYTE  = ~b;
  endtask
endmodule
`default_nettype wire

// ===== dv/cpu_opcode_subset_and_debug_step_test.sv
/*
  Self-checking bench for the opcode subset and debug step core.
  Assumes the core, its package and map header, and the host model.
*/
`timescale 1ns/10ps
`default_nettype none
`include "cpudbg_map.svh"
module cpu_opcode_subset_and_debug_step_test;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        dbg_valid;
  logic [7:0]  dbg_byte;
  logic        debug_mode = 1'b1;
  logic        read_prot = 1'b0;
  logic [7:0]  rf_val = 8'h00;
  logic [7:0]  rf_src = 8'h00;
  logic [7:0]  index = 8'h00;
  logic [11:0] base_addr = 12'h000;
  logic [7:0]  pm [256];
  logic [15:0] pm_addr, pc;
  logic [11:0] rf_addr, ea, sp;
  logic [7:0]  rf_wdata, flags, last_wd;
  logic        rf_we, irq_block, busy, up;
  int          n_errors = 0;
  int          n_compared = 0;
  int          n_we = 0;

  always #5 clk = ~clk;

  always @(posedge clk) begin
    if (rf_we === 1'b1) begin
      n_we++;
      last_wd = rf_wdata;
    end
  end

  cpudbg_host cpudbg_host_inst (.CLK(clk), .DBG_VALID(dbg_valid), .DBG_BYTE(dbg_byte));

  cpudbg_core #(.AW(16)) cpudbg_core_inst (
    .CLK(clk), .RST(rst), .DBG_VALID(dbg_valid), .DBG_BYTE(dbg_byte),
    .DEBUG_MODE(debug_mode), .READ_PROT(read_prot), .PM_RDATA(pm[pm_addr[7:0]]),
    .RF_RDATA((rf_addr[11:8] == 4'hF) ? rf_src : rf_val), .INDEX(index),
    .BASE_ADDR(base_addr), .PM_ADDR(pm_addr),
    .RF_ADDR(rf_addr), .RF_WDATA(rf_wdata), .RF_WE(rf_we), .EA(ea), .PC(pc),
    .SP(sp), .FLAGS(flags), .IRQ_BLOCK(irq_block), .BUSY(busy));

  // ==============================
  // shared tasks
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_errors++;
      $display("wrong value at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask

  task automatic conclude();
    if (n_errors == 0 && n_compared > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  function automatic logic [7:0] fl(input logic z, input logic s);
    fl = 8'h00;
    fl[`FL_Z] = z;
    fl[`FL_S] = s;
  endfunction

  // sends n bytes, then waits boundedly for the command to finish
  task automatic cmd(input logic [7:0] b0, input logic [7:0] b1, input logic [7:0] b2,
                     input int n);
    logic [7:0] b [3];
    int         k;
    b = '{b0, b1, b2};
    for (int i = 0; i < n; i++) begin
      cpudbg_host_inst.send(b[i]);
    end
    k = 0;
    while (busy !== 1'b1 && k < 4) begin
      @(posedge clk);
      #1;
      k++;
    end
    up = (busy === 1'b1);
    k = 0;
    while (busy !== 1'b0 && k < 80) begin
      @(posedge clk);
      #1;
      k++;
    end
    check(k < 80, 1'b1);
  endtask

  // ==============================
  // scenarios
  task automatic refusals();
    debug_mode = 1'b0;
    cmd(`CMD_STEP, 8'h00, 8'h00, 1);
    check(up, 1'b0);
    debug_mode = 1'b1;
    read_prot = 1'b1;
    cmd(`CMD_STUFF, `OP_ATOMIC, 8'h00, 2);
    check(up, 1'b0);
    cmd(`CMD_STEP, 8'h00, 8'h00, 1);
    check(up, 1'b0);
    read_prot = 1'b0;
    check(pc, 16'h0000);
  endtask

  task automatic indexed();
    base_addr = 12'h100;
    index = 8'h80;
    repeat (2) @(posedge clk);
    #1;
    check(ea, 12'h080);
    index = 8'h7F;
    repeat (2) @(posedge clk);
    #1;
    check(ea, 12'h17F);
  endtask

  task automatic step_xor();
    int w;
    w = n_we;
    pm[0] = `OP_XOR_EXTENDED_OP_IM;
    rf_val = 8'hC3;
    cmd(`CMD_STEP, 8'h00, 8'h00, 1);
    check(last_wd, 8'hFF);
    check(n_we - w, 1);
    check(flags, fl(1'b0, 1'b1));
    check(pc, 16'h0004);
  endtask

  task automatic atomic_span();
    pm[4] = `OP_ATOMIC;
    pm[5] = `OP_REVERSE;
    pm[7] = `OP_REVERSE;
    pm[9] = `OP_REVERSE;
    rf_val = 8'h0E;
    cmd(`CMD_STEP, 8'h00, 8'h00, 1);
    check(irq_block, 1'b1);
    check(flags, fl(1'b0, 1'b1));
    check(pc, 16'h0005);
    for (int i = 0; i < 3; i++) begin
      cmd(`CMD_STEP, 8'h00, 8'h00, 1);
      check(irq_block, i < 2);
      check(last_wd, 8'h70);
    end
    check(flags, fl(1'b0, 1'b0));
    check(pc, 16'h000B);
  endtask

  task automatic bit_jump();
    pm[11] = `OP_BTJ_R;
    pm[12] = 8'hB0;
    pm[13] = 8'h10;
    rf_val = 8'h08;
    cmd(`CMD_STEP, 8'h00, 8'h00, 1);
    check(pc, 16'h001E);
    pm[30] = `OP_BTJ_IR;
    pm[31] = 8'h30;
    pm[32] = 8'h10;
    cmd(`CMD_STEP, 8'h00, 8'h00, 1);
    check(pc, 16'h0021);
  endtask

  task automatic trap_vec();
    int w;
    w = n_we;
    pm[33] = `OP_TRAP;
    pm[34] = 8'hFF;
    cmd(`CMD_STEP, 8'h00, 8'h00, 1);
    check(sp, 12'hFFD);
    check(n_we - w, 3);
    check(pc, 16'h083C);
    check(flags, fl(1'b0, 1'b0));
    check(last_wd, 8'h00);
    check(rf_addr, 12'h0FF);
    check(pm_addr, 16'h00FF);
  endtask

  task automatic exec_stuff();
    rf_val = 8'h01;
    cmd(`CMD_EXEC, `OP_REVERSE, 8'h3C, 3);
    check(last_wd, 8'h80);
    check(pc, 16'h083C);
    check(flags, fl(1'b0, 1'b1));
    pm[8'h3C] = `OP_XOR_EXTENDED_OP_IM;
    rf_val = 8'hA5;
    cmd(`CMD_STUFF, `OP_AND_EXTENDED_OP_IM, 8'h00, 2);
    check(last_wd, 8'h24);
    check(flags, fl(1'b0, 1'b0));
    check(pc, 16'h0840);
  endtask

  // source operand from a register in the upper page, destination 33C
  task automatic ext_reg();
    pm[8'h40] = `OP_AND_EXTENDED_OP_ER;
    pm[8'h41] = 8'hF3;
    pm[8'h44] = `OP_XOR_EXTENDED_OP_ER;
    pm[8'h45] = 8'hF3;
    rf_src = 8'h0F;
    cmd(`CMD_STEP, 8'h00, 8'h00, 1);
    check(last_wd, 8'h05);
    check(rf_addr, 12'h33C);
    cmd(`CMD_STEP, 8'h00, 8'h00, 1);
    check(last_wd, 8'hAA);
    check(flags, fl(1'b0, 1'b1));
    check(pc, 16'h0848);
  endtask

  // ==============================
  // main sequence and watchdog
  initial begin
    for (int i = 0; i < 256; i++) begin
      pm[i] = 8'h3C;
    end
    repeat (6) @(posedge clk);
    #1;
    rst = 1'b0;
    refusals();
    indexed();
    step_xor();
    atomic_span();
    bit_jump();
    trap_vec();
    exec_stuff();
    ext_reg();
    conclude();
  end

  // whole run is well under a thousand cycles; this leaves wide margin
  initial begin
    #100000;
    n_errors++;
    conclude();
  end
endmodule
`default_nettype wire
